// ### core/asp_pkg.sv
// constants, register map and state types of the async serial port
package asp_pkg;
  // register bus geometry
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h098;
  localparam logic [9:0] IDX_DATA = 10'h099;
  localparam logic [9:0] IDX_IRQ_EN = 10'h09a;
  // control register fields
  localparam int CTRL_FMT_BIT = 7;
  localparam int CTRL_ONE_BIT = 6;
  localparam int CTRL_MPF_BIT = 5;
  localparam int CTRL_REN_BIT = 4;
  localparam int CTRL_NTB_BIT = 3;
  localparam int CTRL_NRB_BIT = 2;
  localparam int CTRL_TDF_BIT = 1;
  localparam int CTRL_RDF_BIT = 0;
  // interrupt enable register field
  localparam int IRQ_EN_BIT = 0;
  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic IRQ_EN_RESET = 1'b0;
  // frame format select values
  localparam logic FMT_8BIT = 1'b0;
  localparam logic FMT_9BIT = 1'b1;
  // bit timing: ticks per bit and the mid-bit tick of the start bit
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] TICK_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] TICK_MID = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [2:0] DATA_LAST = 3'h7;
  // transmit buffer geometry
  localparam int TXQ_WIDTH = 8;
  localparam int TXQ_DEPTH = 16;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // frame phases shared by both directions
  typedef enum logic [2:0] {
    ASP_IDLE,
    ASP_START,
    ASP_DATA,
    ASP_NINTH,
    ASP_STOP
  } asp_phase_t;
endpackage : asp_pkg

// ### core/asp_fifo.sv
// flip-flop fifo with valid and ready on both sides
module asp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [PW:0] cnt;
  } asp_fifo_st_t;

  asp_fifo_st_t q;
  asp_fifo_st_t d;
  logic push;
  logic pop;

  // handshakes; full and empty come straight from the count
  assign in_ready_o = (q.cnt != FULL);
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o = q.mem[q.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // pointer and count update; depth is a power of two so pointers wrap
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data_i;
      d.wr = q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = q.rd + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : asp_fifo

// ### core/asp_core.sv
// async serial port: axi4-lite registers, transmitter, receiver
module asp_core (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // bit-rate tick, one cycle per timer overflow
  input wire logic bit_tick_i,
  // serial line
  input wire logic rxd_i,
  output logic txd_o,
  // interrupt request
  output logic irq_o,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [asp_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [asp_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [asp_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [asp_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  typedef struct packed {
    // bus slave
    logic awready;
    logic wready;
    logic [9:0] aw_idx;
    logic [7:0] wbyte;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // control register
    logic fmt;
    logic mpf;
    logic ren;
    logic ntb;
    logic nrb;
    logic tdf;
    logic rdf;
    logic irq_en;
    logic irq;
    // receive latch
    logic [7:0] rbuf;
    // transmitter
    asp_pkg::asp_phase_t tx_ph;
    logic [3:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_n9;
    logic txd;
    // receiver
    logic rx_s1;
    logic rx_s2;
    asp_pkg::asp_phase_t rx_ph;
    logic [3:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_n9;
  } asp_core_st_t;

  asp_core_st_t q;
  asp_core_st_t d;

  // transmit buffer handshakes
  logic txq_in_valid;
  logic txq_in_ready;
  logic txq_out_valid;
  logic txq_out_ready;
  logic [7:0] txq_out_data;

  // write and read path decode, receive acceptance
  logic wr_both;
  logic wr_buf;
  logic wr_ctrl;
  logic wr_irq;
  logic wr_fire;
  logic [9:0] ar_idx;
  logic [7:0] ctrl_rd;
  logic rx_ninth;
  logic rx_accept;

  // outputs come straight from the state register
  assign txd_o = q.txd;
  assign irq_o = q.irq;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // a write is ready to act once both its address and data are held
  assign wr_both = !q.awready && !q.wready && !q.bvalid;
  assign wr_buf = (q.aw_idx == asp_pkg::IDX_DATA);
  assign wr_ctrl = (q.aw_idx == asp_pkg::IDX_CTRL);
  assign wr_irq = (q.aw_idx == asp_pkg::IDX_IRQ_EN);
  // a buffer write waits for room, so a full queue stalls the response
  assign txq_in_valid = wr_both && wr_buf && q.wlane0;
  assign wr_fire = wr_both && (!txq_in_valid || txq_in_ready);
  // the queue drains only into an idle transmitter
  assign txq_out_ready = (q.tx_ph == asp_pkg::ASP_IDLE);
  assign ar_idx = s_axi_araddr[asp_pkg::AXI_ADDR_W-1:2];

  // control register as software sees it; bit six always reads one
  assign ctrl_rd = {q.fmt, 1'b1, q.mpf, q.ren, q.ntb, q.nrb, q.tdf, q.rdf};

  // acceptance test at the stop bit sample
  assign rx_ninth = (q.fmt == asp_pkg::FMT_9BIT) ? q.rx_n9 : q.rx_s2;
  assign rx_accept = !q.rdf && (!q.mpf || rx_ninth);

  asp_fifo #(
    .WIDTH(asp_pkg::TXQ_WIDTH),
    .DEPTH(asp_pkg::TXQ_DEPTH)
  ) u_txq (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(txq_in_valid),
    .in_ready_o(txq_in_ready),
    .in_data_i(q.wbyte),
    .out_valid_o(txq_out_valid),
    .out_ready_i(txq_out_ready),
    .out_data_o(txq_out_data)
  );

  // next state of the whole block
  always_comb begin
    d = q;

    // write address and data are taken independently, in either order
    if (q.awready && s_axi_awvalid) begin
      d.aw_idx = s_axi_awaddr[asp_pkg::AXI_ADDR_W-1:2];
      d.awready = 1'b0;
    end
    if (q.wready && s_axi_wvalid) begin
      d.wbyte = s_axi_wdata[7:0];
      d.wlane0 = s_axi_wstrb[0];
      d.wready = 1'b0;
    end

    // write effects; only the low byte lane holds register bits
    if (wr_fire) begin
      d.bvalid = 1'b1;
      d.bresp = (wr_buf || wr_ctrl || wr_irq) ?
        asp_pkg::RESP_OKAY : asp_pkg::RESP_SLVERR;
      if (wr_ctrl && q.wlane0) begin
        d.fmt = q.wbyte[asp_pkg::CTRL_FMT_BIT];
        d.mpf = q.wbyte[asp_pkg::CTRL_MPF_BIT];
        d.ren = q.wbyte[asp_pkg::CTRL_REN_BIT];
        d.ntb = q.wbyte[asp_pkg::CTRL_NTB_BIT];
        d.nrb = q.wbyte[asp_pkg::CTRL_NRB_BIT];
        d.tdf = q.wbyte[asp_pkg::CTRL_TDF_BIT];
        d.rdf = q.wbyte[asp_pkg::CTRL_RDF_BIT];
      end
      if (wr_irq && q.wlane0) begin
        d.irq_en = q.wbyte[asp_pkg::IRQ_EN_BIT];
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end

    // reads answer one cycle after the address is taken
    if (q.arready && s_axi_arvalid) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = asp_pkg::RESP_OKAY;
      if (ar_idx == asp_pkg::IDX_CTRL) begin
        d.rdata = {24'h000000, ctrl_rd};
      end else if (ar_idx == asp_pkg::IDX_DATA) begin
        d.rdata = {24'h000000, q.rbuf};
      end else if (ar_idx == asp_pkg::IDX_IRQ_EN) begin
        d.rdata = {31'h00000000, q.irq_en};
      end else begin
        d.rdata = 32'h00000000;
        d.rresp = asp_pkg::RESP_SLVERR;
      end
    end
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end

    // transmitter: a queued byte starts a frame at once from idle
    if (q.tx_ph == asp_pkg::ASP_IDLE) begin
      d.txd = 1'b1;
      if (txq_out_valid) begin
        d.tx_ph = asp_pkg::ASP_START;
        d.tx_sh = txq_out_data;
        d.tx_n9 = q.ntb;
        d.tx_cnt = 4'h0;
        d.tx_bit = 3'h0;
        d.txd = 1'b0;
      end
    end else if (bit_tick_i) begin
      d.tx_cnt = q.tx_cnt + 1'b1;
      if (q.tx_cnt == asp_pkg::TICK_LAST) begin
        unique case (q.tx_ph)
          asp_pkg::ASP_START: begin
            d.tx_ph = asp_pkg::ASP_DATA;
            d.txd = q.tx_sh[0];
          end
          asp_pkg::ASP_DATA: begin
            if (q.tx_bit == asp_pkg::DATA_LAST) begin
              if (q.fmt == asp_pkg::FMT_9BIT) begin
                d.tx_ph = asp_pkg::ASP_NINTH;
                d.txd = q.tx_n9;
              end else begin
                d.tx_ph = asp_pkg::ASP_STOP;
                d.txd = 1'b1;
                d.tdf = 1'b1;
              end
            end else begin
              d.tx_bit = q.tx_bit + 1'b1;
              d.tx_sh = {1'b0, q.tx_sh[7:1]};
              d.txd = q.tx_sh[1];
            end
          end
          asp_pkg::ASP_NINTH: begin
            d.tx_ph = asp_pkg::ASP_STOP;
            d.txd = 1'b1;
            d.tdf = 1'b1;
          end
          asp_pkg::ASP_STOP: begin
            d.tx_ph = asp_pkg::ASP_IDLE;
          end
          asp_pkg::ASP_IDLE: begin
            d.tx_ph = asp_pkg::ASP_IDLE;
          end
        endcase
      end
    end

    // line synchroniser; only the second stage is read below
    d.rx_s1 = rxd_i;
    d.rx_s2 = q.rx_s1;

    // receiver: dropping enable abandons a frame in flight
    if (!q.ren) begin
      d.rx_ph = asp_pkg::ASP_IDLE;
    end else if (q.rx_ph == asp_pkg::ASP_IDLE) begin
      if (!q.rx_s2) begin
        d.rx_ph = asp_pkg::ASP_START;
        d.rx_cnt = 4'h0;
        d.rx_bit = 3'h0;
      end
    end else if (bit_tick_i) begin
      d.rx_cnt = q.rx_cnt + 1'b1;
      unique case (q.rx_ph)
        asp_pkg::ASP_START: begin
          // a start shorter than half a bit is taken as a glitch
          if (q.rx_cnt == asp_pkg::TICK_MID) begin
            d.rx_cnt = 4'h0;
            d.rx_ph = q.rx_s2 ? asp_pkg::ASP_IDLE : asp_pkg::ASP_DATA;
          end
        end
        asp_pkg::ASP_DATA: begin
          if (q.rx_cnt == asp_pkg::TICK_LAST) begin
            d.rx_sh = {q.rx_s2, q.rx_sh[7:1]};
            d.rx_bit = q.rx_bit + 1'b1;
            if (q.rx_bit == asp_pkg::DATA_LAST) begin
              d.rx_ph = (q.fmt == asp_pkg::FMT_9BIT) ?
                asp_pkg::ASP_NINTH : asp_pkg::ASP_STOP;
            end
          end
        end
        asp_pkg::ASP_NINTH: begin
          if (q.rx_cnt == asp_pkg::TICK_LAST) begin
            d.rx_n9 = q.rx_s2;
            d.rx_ph = asp_pkg::ASP_STOP;
          end
        end
        asp_pkg::ASP_STOP: begin
          // the flag sets at the stop sample, not at the end of the bit
          if (q.rx_cnt == asp_pkg::TICK_LAST) begin
            d.rx_ph = asp_pkg::ASP_IDLE;
            if (rx_accept) begin
              d.rbuf = q.rx_sh;
              d.nrb = rx_ninth;
              d.rdf = 1'b1;
            end
          end
        end
        asp_pkg::ASP_IDLE: begin
          d.rx_ph = asp_pkg::ASP_IDLE;
        end
      endcase
    end

    // request follows the flags; a hardware set beats a same-cycle clear
    d.irq = q.irq_en && (q.tdf || q.rdf);
  end

  // one register for all state except the transmit queue, which keeps its own
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.fmt <= asp_pkg::CTRL_RESET[asp_pkg::CTRL_FMT_BIT];
      q.irq_en <= asp_pkg::IRQ_EN_RESET;
      q.rbuf <= asp_pkg::DATA_RESET;
      q.txd <= 1'b1;
      q.rx_s1 <= 1'b1;
      q.rx_s2 <= 1'b1;
      q.tx_ph <= asp_pkg::ASP_IDLE;
      q.rx_ph <= asp_pkg::ASP_IDLE;
    end else begin
      q <= d;
    end
  end
endmodule : asp_core

// ### bench/asp_core_monitor.sv
// bus and line checker for the serial port core
module asp_core_monitor (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // line and interrupt
  input wire logic txd_o,
  input wire logic irq_o,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [asp_pkg::AXI_DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // answers stand until the master takes them
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("rvalid dropped");
  // read answers one cycle after the address is taken
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("late read answer");
  // a full queue may hold the response back for about one frame
  chk_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_awready && !s_axi_wready
    ##[1:1000] s_axi_bvalid) else $error("write never answered");
  chk_aw_block: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  chk_err_zero: assert property (s_axi_rvalid &&
    s_axi_rresp != asp_pkg::RESP_OKAY |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  // only a register write can take the request down
  chk_irq_sticky: assert property ($fell(irq_o) |->
    s_axi_bvalid || $past(s_axi_bvalid)) else $error("irq dropped alone");
  // a start bit lasts a whole bit time, far beyond eight cycles
  chk_start_hold: assert property ($fell(txd_o) |-> !txd_o [*8])
    else $error("start bit too short");
endmodule : asp_core_monitor

bind asp_core asp_core_monitor asp_core_monitor_inst (
  .clk_sys_i, .rst_n_i, .txd_o, .irq_o,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp
);

// ### bench/asp_remote_port.sv
// remote serial port on the far side of the line
module asp_remote_port (
  // clock and bit tick
  input wire logic clk_sys_i,
  input wire logic bit_tick_i,
  // serial line
  input wire logic line_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // line idles high between frames
  initial line_o = 1'h1;
  // both sides share the tick, so bit times match exactly
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      while (!bit_tick_i) @(posedge clk_sys_i);
    end
  endtask : ticks
  // start bit, then n bits lsb first, the last being the stop bit
  // the last bit lets go of the line after 12 ticks: a zero stop bit
  // must not still be low when the receiver checks a new start at
  // mid-bit, or it would frame a second byte that was never sent
  task automatic send(input logic [9:0] bits, input int n);
    line_o <= 1'h0;
    ticks(16);
    for (int i = 0; i < n; i++) begin
      line_o <= bits[i];
      ticks(i == n - 1 ? 12 : 16);
    end
    line_o <= 1'h1;
    ticks(4);
  endtask : send
  // sample a frame from the device in mid-bit
  task automatic recv(input int n, output logic [9:0] bits);
    bits = 10'h3ff;
    @(posedge clk_sys_i);
    while (line_i) @(posedge clk_sys_i);
    ticks(8);
    for (int i = 0; i < n; i++) begin
      ticks(16);
      bits[i] = line_i;
    end
  endtask : recv
endmodule : asp_remote_port

// ### bench/tb_asp_core.sv
// self-checking bench of the serial port core
module tb_asp_core;
  timeunit 1ns;
  timeprecision 1ns;
  // design ports
  logic clk_sys_i, rst_n_i, rxd_i, txd_o, irq_o;
  logic bit_tick_i = 1'h0;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int errors = 0;
  int compares = 0;
  localparam logic [11:0] A_CTRL = {asp_pkg::IDX_CTRL, 2'h0};
  localparam logic [11:0] A_DATA = {asp_pkg::IDX_DATA, 2'h0};
  localparam logic [11:0] A_IRQ = {asp_pkg::IDX_IRQ_EN, 2'h0};
  localparam logic [11:0] A_BAD = 12'h100;
  localparam logic [31:0] ERR = {30'h0, asp_pkg::RESP_SLVERR};

  asp_core asp_core_inst (
    .clk_sys_i, .rst_n_i, .bit_tick_i, .rxd_i, .txd_o, .irq_o,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp
  );
  asp_remote_port asp_remote_port_inst (
    .clk_sys_i, .bit_tick_i, .line_i(txd_o), .line_o(rxd_i)
  );

  // 50 mhz system clock
  initial begin
    clk_sys_i = 1'h0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  // stands in for the outside bit-rate timer; software would set its
  // reload, here a tick on every other cycle keeps frames short
  always @(posedge clk_sys_i) bit_tick_i <= ~bit_tick_i;

  task automatic check(input logic [31:0] got, exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : check

  // bready stays high, so the response is taken where it is seen
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] resp, output int w);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'h1;
    s_axi_wdata <= d;
    w = 0;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      w++;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= a;
    do begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : rd

  // control write also clears both done flags
  task automatic ctl(input logic fmt, mpf, ren, ntb);
    logic [1:0] r;
    int w;
    wr(A_CTRL, {24'h0, fmt, 1'h0, mpf, ren, ntb, 3'h0}, r, w);
  endtask : ctl

  // irq settles one cycle after the flag or enable changes
  task automatic irq_is(input logic e, input string m);
    repeat (3) @(posedge clk_sys_i);
    check(32'(irq_o), 32'(e), m);
  endtask : irq_is

  task automatic test_reset();
    logic [31:0] d;
    logic [1:0] r;
    int w;
    rd(A_CTRL, d, r);
    check(d, {24'h0, asp_pkg::CTRL_RESET}, "ctrl reset");
    rd(A_DATA, d, r);
    check(d, {24'h0, asp_pkg::DATA_RESET}, "buffer reset");
    rd(A_IRQ, d, r);
    check(d, 32'h0, "irq enable reset");
    rd(A_BAD, d, r);
    check({30'h0, r}, ERR, "unmapped read");
    wr(A_BAD, 32'hff, r, w);
    check({30'h0, r}, ERR, "unmapped write");
    $display("test_reset done");
  endtask : test_reset

  // 8-bit with ninth bit 0, then 9-bit with ninth bit 1 and 0
  task automatic test_tx();
    logic [9:0] bits;
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] b;
    int w;
    for (int k = 0; k < 3; k++) begin
      b = 8'ha5 ^ 8'(k);
      ctl(k > 0, 1'h0, 1'h0, k == 1);
      wr(A_DATA, {24'h0, b}, r, w);
      w = 0;
      while (txd_o && w < 8) begin
        @(posedge clk_sys_i);
        w++;
      end
      check(32'(txd_o), 32'h0, "no start");
      asp_remote_port_inst.recv(k > 0 ? 10 : 9, bits);
      check(32'(bits[7:0]), 32'(b), "tx data");
      check(32'(bits[9:8]), k == 2 ? 32'h2 : 32'h3, "tx tail");
      rd(A_CTRL, d, r);
      check(32'(d[asp_pkg::CTRL_TDF_BIT]), 32'h1, "tx done");
      rd(A_DATA, d, r);
      check(d, 32'h0, "buffer read");
    end
    $display("test_tx done");
  endtask : test_tx

  // case: fmt mpf ren keep last rdf nrb 0 | byte | latch
  task automatic test_rx();
    logic [23:0] tab[8] = '{24'h2e1111, 24'h082211, 24'h603311,
      24'h244444, 24'he05544, 24'hee6666, 24'ha47777, 24'hbc8877};
    logic [23:0] c;
    logic [31:0] d;
    logic [1:0] r;
    foreach (tab[i]) begin
      c = tab[i];
      if (!c[20]) ctl(c[23], c[22], c[21], 1'h0);
      asp_remote_port_inst.send({c[23], c[19], c[15:8]}, c[23] ? 10 : 9);
      repeat (4) @(posedge clk_sys_i);
      rd(A_CTRL, d, r);
      check(32'({d[asp_pkg::CTRL_NRB_BIT], d[asp_pkg::CTRL_RDF_BIT]}),
        32'({c[17], c[18]}), "rx flags");
      rd(A_DATA, d, r);
      check(d, 32'(c[7:0]), "rx latch");
    end
    $display("test_rx done");
  endtask : test_rx

  task automatic test_irq();
    logic [1:0] r;
    int w;
    ctl(1'h0, 1'h0, 1'h0, 1'h0);
    wr(A_IRQ, 32'h1, r, w);
    irq_is(1'h0, "irq idle");
    wr(A_DATA, 32'h5a, r, w);
    repeat (400) @(posedge clk_sys_i);
    check(32'(irq_o), 32'h1, "irq on tx");
    wr(A_IRQ, 32'h0, r, w);
    irq_is(1'h0, "irq masked");
    wr(A_IRQ, 32'h1, r, w);
    irq_is(1'h1, "irq unmasked");
    ctl(1'h0, 1'h0, 1'h1, 1'h0);
    irq_is(1'h0, "irq cleared");
    asp_remote_port_inst.send(10'h13c, 9);
    irq_is(1'h1, "irq on rx");
    $display("test_irq done");
  endtask : test_irq

  // fill the queue while the line drains it byte by byte
  task automatic test_fifo();
    logic [9:0] bits;
    logic [1:0] r;
    int w;
    ctl(1'h0, 1'h0, 1'h0, 1'h0);
    fork
      for (int i = 0; i < 18; i++) begin
        wr(A_DATA, 32'(8'hc0 + 8'(i)), r, w);
        check(32'(w > 8), 32'(i == 17), "queue room");
      end
      for (int j = 0; j < 18; j++) begin
        asp_remote_port_inst.recv(9, bits);
        check(32'(bits[8:0]), 32'({1'h1, 8'hc0 + 8'(j)}), "drain");
      end
    join
    $display("test_fifo done");
  endtask : test_fifo

  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // reset for four cycles, then run every scenario
  initial begin
    rst_n_i = 1'h0;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    s_axi_arvalid = 1'h0;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_bready = 1'h1;
    s_axi_rready = 1'h1;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    repeat (2) @(posedge clk_sys_i);
    test_reset();
    test_tx();
    test_rx();
    test_irq();
    test_fifo();
    test_done();
  end

  // all scenarios need roughly 10500 cycles
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    errors++;
    $display("ERROR %0t: watchdog expired", $time);
    test_done();
  end
endmodule : tb_asp_core
